// *** src/cas_alert_ctrl.sv ***
// charger status, sticky alerts and alert line with an apb slave
module cas_alert_ctrl #(
    parameter int unsigned WARMUP_CYCLES = cas_pkg::WARMUP_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic meas_cycle_done,
    input wire cas_pkg::cas_meas_s meas,
    input wire cas_pkg::cas_lim_s lim,
    input wire logic [3:0] loop_raw,
    input wire logic [10:0] state_raw,
    input wire logic ara_done,
    output logic smbalert_o,
    output logic smbalert_oe
);
    // ==========================================================
    // helpers
    // keeps only the highest set bit so the field stays exclusive
    function automatic logic [10:0] keep_one(input logic [10:0] v);
        logic [10:0] r;
        logic found;
        r = 11'h000;
        found = 1'b0;
        for (int i = 10; i >= 0; i--) begin
            if (v[i] && !found) begin
                r[i] = 1'b1;
                found = 1'b1;
            end
        end
        return r;
    endfunction

    // ==========================================================
    // declarations
    logic [3:0] loop_status; // regulation loop in control
    logic [10:0] chg_state; // exclusive charger state
    logic [10:0] chg_state_q; // state one cycle ago
    logic [3:0] loop_q; // loop status one cycle ago
    logic [15:0] lim_alert; // sticky limit alerts
    logic [10:0] st_alert; // sticky state alerts
    logic [3:0] loop_alert; // sticky loop alerts
    logic [15:0] lim_en; // limit alert enables
    logic [10:0] st_en; // state alert enables
    logic [3:0] loop_en; // loop alert enables
    logic [15:0] lim_hold; // conditions seen at last cycle end
    logic [16:0] warm_cnt; // warm-up counter
    logic meas_valid; // warm-up elapsed
    logic alert_pull; // alert line pulled low
    wire [10:0] state_one = keep_one(state_raw);
    wire [10:0] loop_one = keep_one({7'h00, loop_raw});
    wire [15:0] lim_cond;

    // ==========================================================
    // apb decode
    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire [9:0] idx = paddr[11:2];
    wire aligned = (paddr[1:0] == 2'b00);
    wire hit_state = aligned & (idx == cas_pkg::IDX_CHG_STATE);
    wire hit_loop = aligned & (idx == cas_pkg::IDX_LOOP);
    wire hit_lim = aligned & (idx == cas_pkg::IDX_LIM_ALERT);
    wire hit_st = aligned & (idx == cas_pkg::IDX_ST_ALERT);
    wire hit_la = aligned & (idx == cas_pkg::IDX_LOOP_ALERT);
    wire hit_lim_en = aligned & (idx == cas_pkg::IDX_LIM_EN);
    wire hit_st_en = aligned & (idx == cas_pkg::IDX_ST_EN);
    wire hit_loop_en = aligned & (idx == cas_pkg::IDX_LOOP_EN);
    wire mapped = hit_state | hit_loop | hit_lim | hit_st | hit_la
                | hit_lim_en | hit_st_en | hit_loop_en;
    wire wr = access & pwrite & mapped;
    // read mux, unused bits read zero
    wire [31:0] read_word =
        hit_state ? {21'h00000, chg_state} :
        hit_loop ? {28'h0000000, loop_status} :
        hit_lim ? {16'h0000, lim_alert} :
        hit_st ? {21'h00000, st_alert} :
        hit_la ? {28'h0000000, loop_alert} :
        hit_lim_en ? {16'h0000, lim_en} :
        hit_st_en ? {21'h00000, st_en} :
        hit_loop_en ? {28'h0000000, loop_en} : 32'h00000000;

    // zero-wait answer, error on unmapped
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    // read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup) begin
            prdata <= read_word;
        end
    end

    // enable registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lim_en <= cas_pkg::LIM_EN_RST;
            st_en <= cas_pkg::ST_EN_RST;
            loop_en <= cas_pkg::LOOP_EN_RST;
        end else if (wr) begin
            if (hit_lim_en) begin
                lim_en <= pwdata[15:0] & cas_pkg::LIM_USED;
            end
            if (hit_st_en) begin
                st_en <= pwdata[10:0];
            end
            if (hit_loop_en) begin
                loop_en <= pwdata[3:0];
            end
        end
    end

    // ==========================================================
    // status sampling
    // exclusive state and loop bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_status <= 4'h0;
            chg_state <= 11'h000;
            loop_q <= 4'h0;
            chg_state_q <= 11'h000;
        end else begin
            loop_status <= loop_one[3:0];
            chg_state <= state_one;
            loop_q <= loop_status;
            chg_state_q <= chg_state;
        end
    end

    // ==========================================================
    // warm-up timer
    // warm-up count from reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warm_cnt <= 17'h00000;
            meas_valid <= 1'b0;
        end else if (!meas_valid) begin
            if (warm_cnt == 17'(WARMUP_CYCLES - 1)) begin
                meas_valid <= 1'b1;
            end else begin
                warm_cnt <= warm_cnt + 17'h00001;
            end
        end
    end

    // ==========================================================
    // limit comparisons
    // valid results
    assign lim_cond[cas_pkg::LIM_VALID] = meas_valid;
    assign lim_cond[14] = 1'b0;
    assign lim_cond[cas_pkg::LIM_Q_LO] = meas.charge_count < lim.charge_count_lo;
    assign lim_cond[cas_pkg::LIM_Q_HI] = meas.charge_count > lim.charge_count_hi;
    assign lim_cond[cas_pkg::LIM_VB_LO] = meas.vbat < lim.vbat_lo;
    assign lim_cond[cas_pkg::LIM_VB_HI] = meas.vbat > lim.vbat_hi;
    assign lim_cond[cas_pkg::LIM_VI_LO] = meas.vin < lim.vin_lo;
    assign lim_cond[cas_pkg::LIM_VI_HI] = meas.vin > lim.vin_hi;
    assign lim_cond[cas_pkg::LIM_VS_LO] = meas.vsys < lim.vsys_lo;
    assign lim_cond[cas_pkg::LIM_VS_HI] = meas.vsys > lim.vsys_hi;
    assign lim_cond[cas_pkg::LIM_II_HI] = meas.iin > lim.iin_hi;
    assign lim_cond[cas_pkg::LIM_IB_LO] = meas.ibat < lim.ibat_lo;
    assign lim_cond[cas_pkg::LIM_DT_HI] = meas.die_temp > lim.die_temp_hi;
    assign lim_cond[cas_pkg::LIM_SR_HI] = meas.bsr > lim.bsr_hi;
    assign lim_cond[cas_pkg::LIM_COLD] = meas.ntc_ratio > lim.ntc_ratio_hi;
    assign lim_cond[cas_pkg::LIM_HOT] = meas.ntc_ratio < lim.ntc_ratio_lo;

    // conditions latched at measurement cycle end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lim_hold <= 16'h0000;
        end else if (meas_cycle_done) begin
            lim_hold <= lim_cond;
        end
    end

    // ==========================================================
    // sticky alert next values, a set wins over a clear
    // write of zero clears
    wire [15:0] lim_clr = (wr & hit_lim) ? ~pwdata[15:0] : 16'h0000;
    wire [10:0] st_clr = (wr & hit_st) ? ~pwdata[10:0] : 11'h000;
    wire [3:0] loop_clr = (wr & hit_la) ? ~pwdata[3:0] : 4'h0;
    wire [10:0] st_entry = chg_state & ~chg_state_q;
    wire [3:0] loop_entry = loop_status & ~loop_q;
    wire [15:0] next_lim = (lim_alert & lim_en & ~lim_clr) | (lim_en & lim_hold);
    wire [10:0] next_st = (st_alert & st_en & ~st_clr) | (st_en & st_entry);
    wire [3:0] next_loop = (loop_alert & loop_en & ~loop_clr) | (loop_en & loop_entry);
    wire new_rise = |(next_lim & ~lim_alert) | |(next_st & ~st_alert)
                  | |(next_loop & ~loop_alert);

    // alert registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lim_alert <= 16'h0000;
            st_alert <= 11'h000;
            loop_alert <= 4'h0;
        end else begin
            lim_alert <= next_lim;
            st_alert <= next_st;
            loop_alert <= next_loop;
        end
    end

    // ==========================================================
    // alert line
    // held until the response completes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alert_pull <= 1'b0;
        end else if (new_rise) begin
            alert_pull <= 1'b1;
        end else if (ara_done) begin
            alert_pull <= 1'b0;
        end
    end

    // open-drain: drive low when enabled
    assign smbalert_o = 1'b0;
    assign smbalert_oe = alert_pull;

    // ==========================================================
    // assertions
    // limit clear strobe
    sequence clr_lim_s;
        wr && hit_lim;
    endsequence
    // state alert bit 3 written zero with no fresh entry
    sequence clr_st_s;
        wr && hit_st && !pwdata[3] && !st_entry[3];
    endsequence
    // enabled entry into the charge current loop
    sequence loop_enter_s;
        loop_en[1] && loop_status[1] && !loop_q[1];
    endsequence
    // enabled entry into the equalize state
    sequence st_enter_s;
        st_en[10] && chg_state[10] && !chg_state_q[10];
    endsequence

    loop_onehot_a: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot0(loop_status))
        else $error("loop status not exclusive");
    loop_map_a: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot0(loop_raw) |=> loop_status == $past(loop_raw))
        else $error("loop status bit mapping wrong");
    hold_stable_a: assert property (@(posedge pclk) disable iff (!presetn)
        !meas_cycle_done |=> $stable(lim_hold))
        else $error("limit conditions changed mid cycle");
    lim_from_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (lim_alert & ~$past(lim_alert) & ~$past(lim_hold)) == 16'h0000)
        else $error("limit alert set outside a cycle end");
    cond_sample_a: assert property (@(posedge pclk) disable iff (!presetn)
        meas_cycle_done |=> lim_hold == $past(lim_cond))
        else $error("limit conditions not sampled");
    lim_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        (lim_alert & ~$past(lim_en)) == 16'h0000)
        else $error("limit alert set while disabled");
    sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st_alert[0] && st_en[0] && !(wr && hit_st)) |=> st_alert[0])
        else $error("state alert lost without clear");
    clear_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clr_lim_s and (lim_hold[4] == 1'b0) and (pwdata[4] == 1'b0))
        |=> !lim_alert[4])
        else $error("write of zero did not clear");
    clear_state_a: assert property (@(posedge pclk) disable iff (!presetn)
        clr_st_s |=> !st_alert[3])
        else $error("write of zero left state alert");
    reraise_a: assert property (@(posedge pclk) disable iff (!presetn)
        (clr_lim_s and lim_en[1] and lim_hold[1]) |=> lim_alert[1])
        else $error("held condition not re-raised");
    line_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (alert_pull && !ara_done) |=> alert_pull)
        else $error("alert line released early");
    line_pull_a: assert property (@(posedge pclk) disable iff (!presetn)
        new_rise |=> alert_pull)
        else $error("alert line not pulled");
    rise_pull_a: assert property (@(posedge pclk) disable iff (!presetn)
        (|(st_alert & ~$past(st_alert))) |-> alert_pull)
        else $error("new alert did not pull line");
    line_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!alert_pull && !new_rise) |=> !alert_pull)
        else $error("alert line pulled without alert");
    entry_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(st_alert[6]) |-> $past(st_entry[6]))
        else $error("state alert without entry");
    st_enter_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_enter_s |=> st_alert[10])
        else $error("equalize entry not flagged");
    loop_enter_a: assert property (@(posedge pclk) disable iff (!presetn)
        loop_enter_s |=> loop_alert[1])
        else $error("loop entry not flagged");
    warm_valid_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(lim_alert[15]) |-> meas_valid)
        else $error("valid alert before warm-up");
    warm_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !meas_valid |-> !lim_hold[cas_pkg::LIM_VALID])
        else $error("valid condition before warm-up");
    short_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_raw == 11'h001) |=> chg_state == 11'h001)
        else $error("short state flag missing");
    state_excl_a: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot0(chg_state))
        else $error("charger state not exclusive");
endmodule

// *** src/cas_pkg.sv ***
// constants and carrier types for the charger alert and status block
package cas_pkg;
    // ==========================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned WARMUP_US = 12000;
    localparam int unsigned WARMUP_CYCLES = WARMUP_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned WARM_W = 17;
    // ==========================================================
    // register indexes, byte address is four times the index
    localparam logic [9:0] IDX_CHG_STATE = 10'h034;
    localparam logic [9:0] IDX_LOOP = 10'h035;
    localparam logic [9:0] IDX_LIM_ALERT = 10'h036;
    localparam logic [9:0] IDX_ST_ALERT = 10'h037;
    localparam logic [9:0] IDX_LOOP_ALERT = 10'h038;
    localparam logic [9:0] IDX_LIM_EN = 10'h050;
    localparam logic [9:0] IDX_ST_EN = 10'h051;
    localparam logic [9:0] IDX_LOOP_EN = 10'h052;
    // ==========================================================
    // widths, used bits and reset values
    localparam int unsigned LOOP_W = 4;
    localparam int unsigned LIM_W = 16;
    localparam int unsigned ST_W = 11;
    localparam logic [15:0] LIM_USED = 16'hbfff;
    localparam logic [15:0] LIM_EN_RST = 16'h0000;
    localparam logic [10:0] ST_EN_RST = 11'h000;
    localparam logic [3:0] LOOP_EN_RST = 4'h0;
    // ==========================================================
    // limit alert bit positions
    localparam int unsigned LIM_VALID = 15;
    localparam int unsigned LIM_Q_LO = 13;
    localparam int unsigned LIM_Q_HI = 12;
    localparam int unsigned LIM_VB_LO = 11;
    localparam int unsigned LIM_VB_HI = 10;
    localparam int unsigned LIM_VI_LO = 9;
    localparam int unsigned LIM_VI_HI = 8;
    localparam int unsigned LIM_VS_LO = 7;
    localparam int unsigned LIM_VS_HI = 6;
    localparam int unsigned LIM_II_HI = 5;
    localparam int unsigned LIM_IB_LO = 4;
    localparam int unsigned LIM_DT_HI = 3;
    localparam int unsigned LIM_SR_HI = 2;
    localparam int unsigned LIM_COLD = 1;
    localparam int unsigned LIM_HOT = 0;
    // ==========================================================
    // carriers: measurement results and their limits
    typedef struct packed {
        logic [15:0] charge_count;
        logic signed [15:0] vbat;
        logic signed [15:0] vin;
        logic signed [15:0] vsys;
        logic signed [15:0] iin;
        logic signed [15:0] ibat;
        logic signed [15:0] die_temp;
        logic [15:0] bsr;
        logic signed [15:0] ntc_ratio;
    } cas_meas_s;
    typedef struct packed {
        logic [15:0] charge_count_lo;
        logic [15:0] charge_count_hi;
        logic signed [15:0] vbat_lo;
        logic signed [15:0] vbat_hi;
        logic signed [15:0] vin_lo;
        logic signed [15:0] vin_hi;
        logic signed [15:0] vsys_lo;
        logic signed [15:0] vsys_hi;
        logic signed [15:0] iin_hi;
        logic signed [15:0] ibat_lo;
        logic signed [15:0] die_temp_hi;
        logic [15:0] bsr_hi;
        logic signed [15:0] ntc_ratio_hi;
        logic signed [15:0] ntc_ratio_lo;
    } cas_lim_s;
endpackage

// *** verif/cas_host_model.sv ***
// partner model: smbus host that answers the alert line with an alert response
module cas_host_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic smbalert_oe,
    input wire logic serve,
    input wire logic [7:0] delay,
    output logic ara_done
);
    timeunit 1ns;
    timeprecision 1ns;
    // cycles the line has been seen low while serving
    int unsigned wait_n;
    // ==========================================================
    // alert response, after a prompt or slow wait
    // host completes response
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_n <= 0;
            ara_done <= 1'b0;
        end else if (ara_done) begin
            // one-cycle completion pulse
            ara_done <= 1'b0;
            wait_n <= 0;
        end else if (smbalert_oe && serve) begin
            // line low: answer once the wait has run out
            if (wait_n >= delay) begin
                ara_done <= 1'b1;
            end
            wait_n <= wait_n + 1;
        end else begin
            // idle or held off by the bench
            wait_n <= 0;
        end
    end
endmodule

// *** verif/charger_alert_status_controller_bench.sv ***
// self-checking bench for the charger alert and status block
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module charger_alert_status_controller_bench;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // register byte addresses and stimulus sets
    localparam logic [11:0] A_STATE = {cas_pkg::IDX_CHG_STATE, 2'h0};
    localparam logic [11:0] A_LOOP = {cas_pkg::IDX_LOOP, 2'h0};
    localparam logic [11:0] A_LIM = {cas_pkg::IDX_LIM_ALERT, 2'h0};
    localparam logic [11:0] A_ST = {cas_pkg::IDX_ST_ALERT, 2'h0};
    localparam logic [11:0] A_LA = {cas_pkg::IDX_LOOP_ALERT, 2'h0};
    localparam logic [11:0] A_LIMEN = {cas_pkg::IDX_LIM_EN, 2'h0};
    localparam logic [11:0] A_STEN = {cas_pkg::IDX_ST_EN, 2'h0};
    localparam logic [11:0] A_LAEN = {cas_pkg::IDX_LOOP_EN, 2'h0};
    localparam int unsigned WARM = 20; // shortened warm-up
    // every limit violated by the fixed readings
    localparam logic [223:0] LIM_BAD = {16'h0200, 16'h0000, 16'h0001, 16'hffff, 16'h0001,
        16'hffff, 16'h0001, 16'hffff, 16'hffff, 16'h0001, 16'hffff, 16'h0000, 16'hffff, 16'h0001};
    // every reading inside its limits
    localparam logic [223:0] LIM_OK = {16'h0000, 16'hffff, 16'hffff, 16'h0001, 16'hffff,
        16'h0001, 16'hffff, 16'h0001, 16'h0001, 16'hffff, 16'h0001, 16'hffff, 16'h0001, 16'hffff};
    // only battery voltage low and input voltage high
    localparam logic [223:0] LIM_MIX = {16'h0000, 16'hffff, 16'h0001, 16'h0002, 16'hfffe,
        16'hffff, 16'hffff, 16'h0001, 16'h0001, 16'hffff, 16'h0001, 16'hffff, 16'h0001, 16'hffff};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic meas_cycle_done, ara_done, smbalert_o, smbalert_oe, serve;
    cas_pkg::cas_meas_s meas;
    cas_pkg::cas_lim_s lim;
    logic [3:0] loop_raw;
    logic [10:0] state_raw;
    logic [7:0] delay; // host answer wait in cycles
    logic [31:0] d; // last read data
    logic e; // last error response
    int fail_count = 0;
    int checks = 0;
    // ==========================================================
    // design and host model
    cas_alert_ctrl #(.WARMUP_CYCLES(WARM)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas_cycle_done(meas_cycle_done),
        .meas(meas), .lim(lim), .loop_raw(loop_raw), .state_raw(state_raw),
        .ara_done(ara_done), .smbalert_o(smbalert_o), .smbalert_oe(smbalert_oe));
    cas_host_model host_u (.pclk(pclk), .presetn(presetn), .smbalert_oe(smbalert_oe),
        .serve(serve), .delay(delay), .ara_done(ara_done));
    // ==========================================================
    // clock, 100 ns period
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // one apb transfer, result left in d and e
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fail_count++;
            test_done();
        end else begin
            d = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    // end of one measurement cycle
    task automatic cycle();
        meas_cycle_done <= 1'b1;
        @(posedge pclk);
        meas_cycle_done <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    // ==========================================================
    // scenarios
    // reset values, read-only status, unmapped place, reserved enable bit
    task automatic t_regs();
        apb(1'b0, A_LIM, 32'h0);
        `CHK(d, 32'h0)
        apb(1'b1, A_LOOP, 32'hf);
        apb(1'b0, A_LOOP, 32'h0);
        `CHK(d, 32'h0)
        apb(1'b0, 12'hffc, 32'h0);
        `CHK({e, d}, 33'h100000000)
        apb(1'b1, A_LIMEN, 32'hffff);
        apb(1'b0, A_LIMEN, 32'h0);
        `CHK(d, 32'h0000bfff)
    endtask
    // each limit bit 0 to 13 on its own: gating, timing, stickiness, clearing
    task automatic t_limits();
        repeat (WARM) @(posedge pclk);
        for (int i = 0; i < 15; i++) begin
            if (cas_pkg::LIM_USED[i]) begin
                lim <= LIM_BAD;
                apb(1'b1, A_LIMEN, 32'h1 << i);
                apb(1'b0, A_LIM, 32'h0);
                `CHK(d, 32'h0)
                cycle();
                apb(1'b0, A_LIM, 32'h0);
                `CHK(d, 32'h1 << i)
                apb(1'b1, A_LIM, 32'h0);
                apb(1'b0, A_LIM, 32'h0);
                `CHK(d, 32'h1 << i)
                lim <= LIM_OK;
                cycle();
                apb(1'b1, A_LIM, 32'hffff);
                apb(1'b0, A_LIM, 32'h0);
                `CHK(d, 32'h1 << i)
                apb(1'b1, A_LIM, 32'h0);
                apb(1'b0, A_LIM, 32'h0);
                `CHK(d, 32'h0)
            end
        end
        lim <= LIM_MIX;
        apb(1'b1, A_LIMEN, 32'hbfff);
        cycle();
        apb(1'b0, A_LIM, 32'h0);
        `CHK(d, 32'h8900)
        apb(1'b1, A_LIMEN, 32'h0);
        apb(1'b0, A_LIM, 32'h0);
        `CHK(d, 32'h0)
    endtask
    // entry into each charger state or regulation loop
    task automatic t_entry(input bit is_loop);
        int n;
        n = is_loop ? 4 : 11;
        // start from idle inputs so the first step is a real entry
        loop_raw <= 4'h0;
        state_raw <= 11'h0;
        repeat (3) @(posedge pclk);
        apb(1'b1, is_loop ? A_LAEN : A_STEN, 32'h7ff);
        for (int i = 0; i < n; i++) begin
            if (is_loop) begin
                loop_raw <= 4'h1 << i;
            end else begin
                state_raw <= 11'h1 << i;
            end
            repeat (3) @(posedge pclk);
            apb(1'b0, is_loop ? A_LOOP : A_STATE, 32'h0);
            `CHK(d, 32'h1 << i)
            apb(1'b0, is_loop ? A_LA : A_ST, 32'h0);
            `CHK(d, 32'h1 << i)
            apb(1'b1, is_loop ? A_LA : A_ST, 32'h0);
            apb(1'b0, is_loop ? A_LA : A_ST, 32'h0);
            `CHK(d, 32'h0)
        end
        apb(1'b1, is_loop ? A_LAEN : A_STEN, 32'h0);
        loop_raw <= 4'h0;
        state_raw <= 11'h0;
        repeat (3) @(posedge pclk);
        loop_raw <= 4'h1;
        state_raw <= 11'h1;
        repeat (3) @(posedge pclk);
        apb(1'b0, is_loop ? A_LA : A_ST, 32'h0);
        `CHK(d, 32'h0)
    endtask
    // alert line held until a slow host answers
    task automatic t_line();
        int n;
        serve <= 1'b0;
        apb(1'b1, A_STEN, 32'h7ff);
        state_raw <= 11'h4;
        repeat (3) @(posedge pclk);
        `CHK({smbalert_oe, smbalert_o}, 2'b10)
        apb(1'b1, A_ST, 32'h0);
        apb(1'b1, A_STEN, 32'h0);
        repeat (20) @(posedge pclk);
        `CHK(smbalert_oe, 1'b1)
        delay <= 8'h0a;
        serve <= 1'b1;
        n = 0;
        while (smbalert_oe === 1'b1 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        `CHK(smbalert_oe, 1'b0)
        loop_raw <= 4'hf;
        repeat (3) @(posedge pclk);
        apb(1'b0, A_LOOP, 32'h0);
        `CHK(d, 32'h8)
    endtask
    // mid-run reset, then the valid alert waits for the warm-up
    task automatic t_warm();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, A_LIMEN, 32'h8000);
        cycle();
        apb(1'b0, A_LIM, 32'h0);
        `CHK(d, 32'h0)
        repeat (WARM) @(posedge pclk);
        cycle();
        apb(1'b0, A_LIM, 32'h0);
        `CHK(d, 32'h8000)
    endtask
    // ==========================================================
    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        meas_cycle_done = 1'b0;
        meas = {16'h0100, 96'h0, 16'h0100, 16'h0000};
        lim = LIM_OK;
        loop_raw = 4'h0;
        state_raw = 11'h000;
        serve = 1'b1;
        delay = 8'h01;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_limits();
        t_entry(1'b0);
        t_entry(1'b1);
        t_line();
        t_warm();
        test_done();
    end
endmodule
